//--- swrpd_pkg.sv
// ****************************************************************
// Shared constants and types of the single-wire PWM driver
// ****************************************************************
package swrpd_pkg;

  // ****************************************************************
  // Clock and time
  // ****************************************************************
  localparam int CLK_PERIOD_PS       = 5000;
  localparam int BIT_PERIOD_MIN_PS   = 330000;
  localparam int BIT_PERIOD_MAX_PS   = 10000000;
  localparam int BIT_PERIOD_MIN_CYC  =
    (BIT_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BIT_PERIOD_MAX_CYC  = BIT_PERIOD_MAX_PS / CLK_PERIOD_PS;
  localparam int CLK_FREQ_KHZ        = 200000;
  localparam int OSC_FREQ_KHZ        = 12000;
  localparam int OSC_DIV_CYC         = CLK_FREQ_KHZ / OSC_FREQ_KHZ;

  // ****************************************************************
  // Widths and packet layout
  // ****************************************************************
  localparam int PER_W               = 12;
  localparam int CNT_W               = 16;
  localparam int GS_W                = 12;
  localparam int NCH                 = 3;
  localparam int PKT_W               = 48;
  localparam int KEY_LSB             = 36;
  localparam int GS_DATA_W           = NCH * GS_W;
  localparam logic [GS_W-1:0] WRITE_KEY = 12'h3AA;
  localparam logic [PKT_W-1:0] PKT_RESET = 48'h000000000000;

  // ****************************************************************
  // Decision points as fractions and multiples of the bit period
  // ****************************************************************
  localparam int ZERO_NUM            = 9;
  localparam int ZERO_DEN            = 10;
  localparam int ONE_DIV             = 2;
  localparam int FRAME_END_PERIODS   = 4;
  localparam int LATCH_PERIODS       = 8;

  typedef enum logic [4:0] {
    ST_WAIT_FIRST = 5'h01,
    ST_MEASURE    = 5'h02,
    ST_MARK       = 5'h04,
    ST_GAP        = 5'h08,
    ST_FORWARD    = 5'h10
  } swrpd_state_t;

endpackage : swrpd_pkg

//--- swrpd_pwm_if.sv
`timescale 1ns/100ps
// ****************************************************************
// Link between the serial decoder and the PWM engine
// ****************************************************************
interface swrpd_pwm_if;
  import swrpd_pkg::*;
  logic                 osc_tick;
  logic                 load;
  logic [GS_DATA_W-1:0] levels;

  modport ctrl (output osc_tick, output load, output levels);
  modport pwm  (input osc_tick, input load, input levels);
endinterface : swrpd_pwm_if

//--- swrpd_pwm.sv
`timescale 1ns/100ps
module swrpd_pwm
  import swrpd_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  swrpd_pwm_if.pwm            link,
  output      logic [NCH-1:0] led_on
);

  // ****************************************************************
  // Grayscale counter and holding latch
  // ****************************************************************
  logic [GS_W-1:0]      gs_cnt_reg;
  logic [GS_DATA_W-1:0] latch_reg;
  logic                 loaded_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gs_cnt_reg <= '0;
    end else if (link.load) begin
      gs_cnt_reg <= '0;
    end else if (link.osc_tick) begin
      gs_cnt_reg <= gs_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_reg  <= '0;
      loaded_reg <= 1'b0;
    end else if (link.load) begin
      latch_reg  <= link.levels;
      loaded_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Per-channel comparators
  // ****************************************************************
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_chan
      logic [GS_W-1:0] lvl;
      assign lvl = latch_reg[(NCH-1-c)*GS_W +: GS_W];
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          led_on[c] <= 1'b0;
        end else if (link.load) begin
          led_on[c] <= 1'b0;
        end else begin
          // Count zero is the off slot, so full scale stays one short.
          led_on[c] <= (gs_cnt_reg != '0) && (gs_cnt_reg <= lvl);
        end
      end

      property p_zero_never_on;
        @(posedge clk) disable iff (!rst_n)
        (lvl == '0) && $stable(lvl) |=> !led_on[c];
      endproperty
      a_zero_never_on: assert property (p_zero_never_on)
        else $error("channel with zero level turned on");

      property p_off_after_level;
        @(posedge clk) disable iff (!rst_n)
        (gs_cnt_reg == lvl) && (lvl != '0) && link.osc_tick && !link.load
        |=> ##1 !led_on[c];
      endproperty
      a_off_after_level: assert property (p_off_after_level)
        else $error("output stayed on past its level");

      property p_on_at_one;
        @(posedge clk) disable iff (!rst_n)
        (gs_cnt_reg == '0) && (lvl != '0) && link.osc_tick && !link.load
        |=> ##1 (led_on[c] || $past(link.load));
      endproperty
      a_on_at_one: assert property (p_on_at_one)
        else $error("output did not turn on at count one");
    end
  endgenerate

  property p_count_step;
    @(posedge clk) disable iff (!rst_n)
    link.osc_tick && !link.load |=> gs_cnt_reg == $past(gs_cnt_reg) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("grayscale counter missed a tick");

  property p_load_clears;
    @(posedge clk) disable iff (!rst_n)
    link.load |=> (gs_cnt_reg == '0) && (led_on == '0);
  endproperty
  a_load_clears: assert property (p_load_clears)
    else $error("latch event did not restart PWM");

  property p_dark_until_load;
    @(posedge clk) disable iff (!rst_n)
    !loaded_reg |-> led_on == '0;
  endproperty
  a_dark_until_load: assert property (p_dark_until_load)
    else $error("output on before any latch");

endmodule : swrpd_pwm

//--- swrpd_top.sv
`timescale 1ns/100ps
module swrpd_top
  import swrpd_pkg::*;
#(
  parameter int FE_PERIODS  = FRAME_END_PERIODS,
  parameter int LAT_PERIODS = LATCH_PERIODS,
  parameter int OSC_DIV     = OSC_DIV_CYC
)
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           serial_in,
  output      logic           serial_out,
  output      logic [NCH-1:0] led_sink_output
);

  // ****************************************************************
  // Input synchroniser and edge detect
  // ****************************************************************
  logic sin_meta_reg;
  logic sin_sync_reg;
  logic sin_last_reg;
  logic rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sin_meta_reg <= 1'b0;
      sin_sync_reg <= 1'b0;
      sin_last_reg <= 1'b0;
    end else begin
      sin_meta_reg <= serial_in;
      sin_sync_reg <= sin_meta_reg;
      sin_last_reg <= sin_sync_reg;
    end
  end

  assign rise = sin_sync_reg && !sin_last_reg;

  // ****************************************************************
  // Timers
  // ****************************************************************
  swrpd_state_t     state_reg;
  swrpd_state_t     state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [PER_W-1:0] period_reg;
  logic [CNT_W-1:0] half_thr_reg;
  logic [CNT_W-1:0] zero_thr_reg;
  logic [CNT_W-1:0] fe_thr_reg;
  logic [CNT_W-1:0] lat_thr_reg;
  logic             restart_cnt;

  // Saturating counters: a stuck line must not wrap into a false match.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (restart_cnt) begin
      cnt_reg <= CNT_W'(1);
    end else if (cnt_reg != '1) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_cnt_reg <= '0;
    end else if (sin_sync_reg) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // ****************************************************************
  // Bit period measurement
  // ****************************************************************
  logic meas_in_range;
  logic meas_ok;
  logic meas_timeout;

  assign meas_in_range = (cnt_reg >= CNT_W'(BIT_PERIOD_MIN_CYC)) &&
                         (cnt_reg <= CNT_W'(BIT_PERIOD_MAX_CYC));
  assign meas_ok       = (state_reg == ST_MEASURE) && rise && meas_in_range;
  assign meas_timeout  = (state_reg == ST_MEASURE) && !rise &&
                         (cnt_reg > CNT_W'(BIT_PERIOD_MAX_CYC));

  // Thresholds are computed once per measurement, keeping the
  // multipliers off the per-cycle decode path.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_reg   <= '0;
      half_thr_reg <= '0;
      zero_thr_reg <= '0;
      fe_thr_reg   <= '0;
      lat_thr_reg  <= '0;
    end else if (meas_ok) begin
      period_reg   <= PER_W'(cnt_reg);
      half_thr_reg <= CNT_W'(cnt_reg / ONE_DIV);
      zero_thr_reg <= CNT_W'((32'(cnt_reg) * ZERO_NUM) / ZERO_DEN);
      fe_thr_reg   <= CNT_W'(32'(cnt_reg) * FE_PERIODS);
      lat_thr_reg  <= CNT_W'(32'(cnt_reg) * LAT_PERIODS);
    end
  end

  // ****************************************************************
  // Bit decoding and sequence control
  // ****************************************************************
  logic bit_one;
  logic bit_zero;
  logic frame_end;
  logic latch_sequence;
  logic key_ok;
  logic locked_reg;
  logic [PKT_W-1:0] packet_shift_reg;

  // An edge landing between half and 0.9 periods is ignored; the bit
  // then resolves as zero when the 0.9 point passes.
  assign bit_one   = (state_reg == ST_MARK) && rise &&
                     (cnt_reg < half_thr_reg);
  assign bit_zero  = (state_reg == ST_MARK) && !rise &&
                     (cnt_reg == zero_thr_reg);
  assign frame_end = (state_reg == ST_GAP) &&
                     (low_cnt_reg == fe_thr_reg);
  assign latch_sequence = ((state_reg == ST_GAP) ||
                           (state_reg == ST_FORWARD)) &&
                          (low_cnt_reg == lat_thr_reg);
  assign key_ok = packet_shift_reg[KEY_LSB +: GS_W] == WRITE_KEY;
  assign restart_cnt = rise && ((state_reg == ST_WAIT_FIRST) ||
                                (state_reg == ST_MEASURE) ||
                                (state_reg == ST_GAP));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT_FIRST: begin
        if (rise) begin
          state_next = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (meas_ok) begin
          state_next = ST_GAP;
        end else if (meas_timeout) begin
          state_next = ST_WAIT_FIRST;
        end
      end
      ST_MARK: begin
        if (bit_one || bit_zero) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (rise) begin
          state_next = ST_MARK;
        end else if (latch_sequence) begin
          state_next = ST_WAIT_FIRST;
        end else if (frame_end) begin
          state_next = ST_FORWARD;
        end
      end
      ST_FORWARD: begin
        if (latch_sequence) begin
          state_next = ST_WAIT_FIRST;
        end
      end
      default: begin
        state_next = ST_WAIT_FIRST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_WAIT_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  // The packet register is the only copy of incoming data; after frame
  // end it holds still while downstream traffic passes through.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      packet_shift_reg <= PKT_RESET;
    end else if (meas_ok) begin
      packet_shift_reg <= {packet_shift_reg[PKT_W-3:0], 2'b00};
    end else if (bit_one || bit_zero) begin
      packet_shift_reg <= {packet_shift_reg[PKT_W-2:0], bit_one};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_reg <= 1'b0;
    end else if (latch_sequence) begin
      locked_reg <= 1'b0;
    end else if (frame_end) begin
      locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= locked_reg && sin_sync_reg;
    end
  end

  // ****************************************************************
  // Oscillator tick and PWM engine
  // ****************************************************************
  localparam int DIV_W = $clog2(OSC_DIV + 1);
  logic [DIV_W-1:0] div_reg;
  logic             tick_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(OSC_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  swrpd_pwm_if pwm_link ();

  assign pwm_link.osc_tick = tick_reg;
  assign pwm_link.load     = latch_sequence && key_ok;
  assign pwm_link.levels   = packet_shift_reg[GS_DATA_W-1:0];

  swrpd_pwm u_pwm (
    .clk    (clk),
    .rst_n  (rst_n),
    .link   (pwm_link.pwm),
    .led_on (led_sink_output)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_load_needs_key;
    @(posedge clk) disable iff (!rst_n)
    pwm_link.load |-> latch_sequence &&
      (packet_shift_reg[PKT_W-1 -: GS_W] == WRITE_KEY);
  endproperty
  a_load_needs_key: assert property (p_load_needs_key)
    else $error("levels loaded without a valid key");

  property p_bad_key_no_load;
    @(posedge clk) disable iff (!rst_n)
    latch_sequence && !key_ok |-> !pwm_link.load;
  endproperty
  a_bad_key_no_load: assert property (p_bad_key_no_load)
    else $error("levels loaded with a wrong key");

  property p_locked_frozen;
    @(posedge clk) disable iff (!rst_n)
    locked_reg && $past(locked_reg) |-> $stable(packet_shift_reg);
  endproperty
  a_locked_frozen: assert property (p_locked_frozen)
    else $error("packet changed after frame end");

  property p_measure_zeros;
    @(posedge clk) disable iff (!rst_n)
    meas_ok |=> (packet_shift_reg[1:0] == 2'b00) &&
      (packet_shift_reg[PKT_W-1:2] == $past(packet_shift_reg[PKT_W-3:0]));
  endproperty
  a_measure_zeros: assert property (p_measure_zeros)
    else $error("measurement did not shift two zeros");

  property p_one_shift;
    @(posedge clk) disable iff (!rst_n)
    bit_one |=> packet_shift_reg ==
      {$past(packet_shift_reg[PKT_W-2:0]), 1'b1};
  endproperty
  a_one_shift: assert property (p_one_shift)
    else $error("one bit not shifted in at the low end");

  property p_period_range;
    @(posedge clk) disable iff (!rst_n)
    $rose(state_reg == ST_GAP) && $past(state_reg == ST_MEASURE)
    |-> (period_reg >= PER_W'(BIT_PERIOD_MIN_CYC)) &&
        (period_reg <= PER_W'(BIT_PERIOD_MAX_CYC));
  endproperty
  a_period_range: assert property (p_period_range)
    else $error("bit period stored out of range");

  property p_zero_point;
    @(posedge clk) disable iff (!rst_n)
    bit_zero |-> (32'(cnt_reg) * ZERO_DEN) / ZERO_NUM <= 32'(period_reg);
  endproperty
  a_zero_point: assert property (p_zero_point)
    else $error("zero decided after the 0.9 point");

  property p_forward_follows;
    @(posedge clk) disable iff (!rst_n)
    locked_reg |=> serial_out == $past(sin_sync_reg);
  endproperty
  a_forward_follows: assert property (p_forward_follows)
    else $error("forwarded line does not follow the input");

endmodule : swrpd_top

//--- swrpd_host_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Host that drives the single-wire serial input of the driver
// ****************************************************************
module swrpd_host_model
  import swrpd_pkg::*;
(
  input  wire logic clk,
  output      logic serial_in
);
  localparam int HIGH_CYC = 8;

  initial serial_in = 1'b0;

  // Every task is entered on a falling edge, so each change of the line
  // lands half a cycle away from the edge that samples it.
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic pulse();
    serial_in = 1'b1;
    idle(HIGH_CYC);
    serial_in = 1'b0;
  endtask : pulse

  // A one carries its second rise at a quarter period, well inside the
  // half-period window, so synchroniser lag cannot push it out.
  task automatic send_bit(input logic b, input int per);
    pulse();
    if (b) begin
      idle(per / 4 - HIGH_CYC);
      pulse();
      idle(per - per / 4 - HIGH_CYC);
    end else begin
      idle(per - HIGH_CYC);
    end
  endtask : send_bit

  // The two leading zero bits of the key double as the period measurement.
  task automatic send_packet(input logic [PKT_W-1:0] pkt, input int per);
    for (int i = PKT_W - 1; i >= 0; i--) begin
      send_bit(pkt[i], per);
    end
  endtask : send_packet

  task automatic hold_low(input int periods, input int per);
    serial_in = 1'b0;
    idle(periods * per);
  endtask : hold_low
endmodule : swrpd_host_model

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  import swrpd_pkg::*;
  localparam int OSC_DIV_TB = 2;
  localparam int PWM_SPAN   = 4096 * OSC_DIV_TB;

  logic           clk;
  logic           rst_n;
  logic           serial_in;
  logic           serial_out;
  logic [NCH-1:0] led_sink_output;
  int             err_total = 0;
  int             checked   = 0;
  int             on_cnt[NCH];
  int             out_rises;
  logic           count_en  = 1'b0;
  logic           so_q      = 1'b0;

  swrpd_top #(.OSC_DIV(OSC_DIV_TB)) u_swrpd_top (
    .clk             (clk),
    .rst_n           (rst_n),
    .serial_in       (serial_in),
    .serial_out      (serial_out),
    .led_sink_output (led_sink_output)
  );

  swrpd_host_model u_swrpd_host_model (
    .clk       (clk),
    .serial_in (serial_in)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    so_q <= serial_out;
    if (count_en && serial_out === 1'b1 && so_q === 1'b0) out_rises++;
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Levels are packed channel 0 first, the order in which they are sent.
  function automatic logic [PKT_W-1:0] pack(input logic [GS_W-1:0] key,
                                            input logic [GS_W-1:0] c0,
                                            input logic [GS_W-1:0] c1,
                                            input logic [GS_W-1:0] c2);
    return {key, c0, c1, c2};
  endfunction : pack

  // Any window of one whole PWM period sees each output on exactly
  // level times the tick divider, wherever the window starts.
  task automatic expect_levels(input logic [PKT_W-1:0] pkt);
    logic [GS_W-1:0] lvl;
    repeat (100) @(negedge clk);
    for (int c = 0; c < NCH; c++) on_cnt[c] = 0;
    repeat (PWM_SPAN) begin
      @(negedge clk);
      for (int c = 0; c < NCH; c++) begin
        if (led_sink_output[c] === 1'b1) on_cnt[c]++;
      end
    end
    for (int c = 0; c < NCH; c++) begin
      lvl = pkt[KEY_LSB - 1 - c * GS_W -: GS_W];
      check("on_time", 16'(lvl * OSC_DIV_TB), 16'(on_cnt[c]));
    end
  endtask : expect_levels

  task automatic write_one(input logic [PKT_W-1:0] pkt, input int per);
    u_swrpd_host_model.send_packet(pkt, per);
    u_swrpd_host_model.hold_low(LATCH_PERIODS + 1, per);
  endtask : write_one

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic bad;
    bad = 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (led_sink_output !== 3'h0 || serial_out !== 1'b0) bad = 1'b1;
    end
    check("idle_outputs", 16'h0000, 16'(bad));
  endtask : t_reset

  task automatic t_load(output logic [PKT_W-1:0] pkt);
    pkt = pack(WRITE_KEY, 12'h001, 12'h000, 12'hFFF);
    // A too-short interval must be refused, then the measurement times out.
    u_swrpd_host_model.pulse();
    u_swrpd_host_model.idle(32);
    u_swrpd_host_model.pulse();
    u_swrpd_host_model.idle(2100);
    write_one(pkt, 80);
    expect_levels(pkt);
  endtask : t_load

  task automatic t_bad_key(input logic [PKT_W-1:0] kept);
    write_one(pack(12'h3AB, 12'h800, 12'h800, 12'h800), 120);
    expect_levels(kept);
  endtask : t_bad_key

  task automatic t_chain();
    logic [PKT_W-1:0] own;
    logic [PKT_W-1:0] fwd;
    own = pack(WRITE_KEY, 12'h800, 12'hFFE, 12'h003);
    fwd = pack(WRITE_KEY, 12'h001, 12'h001, 12'h001);
    u_swrpd_host_model.send_packet(own, 70);
    u_swrpd_host_model.hold_low(FRAME_END_PERIODS + 1, 70);
    out_rises = 0;
    count_en = 1'b1;
    write_one(fwd, 70);
    count_en = 1'b0;
    check("fwd_rises", 16'(PKT_W + $countones(fwd)), 16'(out_rises));
    expect_levels(own);
  endtask : t_chain

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    logic [PKT_W-1:0] first;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_load(first);
    t_bad_key(first);
    t_chain();
    stop_test();
  end
endmodule : testbench
